// ==== rtl/pps_pkg.sv ====
package pps_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FREQ_LOW_HZ = 30_000;
   localparam int unsigned FREQ_MID_HZ = 60_000;
   localparam int unsigned FREQ_HIGH_HZ = 132_000;
   localparam int unsigned FREQ_FLOOR_HZ = 15_000;
   localparam int unsigned JITTER_PCT = 7;
   localparam int unsigned JITTER_RATE_HZ = 200;
   localparam int unsigned TICK_US = 100;
   localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SOFT_START_MS = 8;
   localparam int unsigned SS_TICKS = SOFT_START_MS * 1000 / TICK_US;
   localparam int unsigned OVERLOAD_DELAY_MS = 50;
   localparam int unsigned RESTART_MS = 1000;
   localparam int unsigned RESTART_TICKS = RESTART_MS * 1000 / TICK_US;
   localparam int unsigned UV_DEB_MS = 30;
   localparam int unsigned UV_DEB_TICKS = UV_DEB_MS * 1000 / TICK_US;
   localparam int unsigned UV_REST_MS = 30;
   localparam int unsigned UV_REST_TICKS = UV_REST_MS * 1000 / TICK_US;
   localparam int unsigned MIN_ON_NS = 400;
   localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_RUN = 4'h2,
      ST_FAULT = 4'h4,
      ST_DIS = 4'h8
   } pps_state_t;

   function automatic int unsigned pps_freq_hz(input int unsigned sel);
      if (sel == 0) begin
         return FREQ_LOW_HZ;
      end else if (sel == 1) begin
         return FREQ_MID_HZ;
      end
      return FREQ_HIGH_HZ;
   endfunction
endpackage

// ==== rtl/pps_updown.sv ====
`timescale 1ns/1ps
`default_nettype none
module pps_updown
   import pps_pkg::*;
#(
   parameter int unsigned W = 16,
   parameter int unsigned EOC = 100
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic clear_in,
   input wire logic step_in,
   input wire logic up_in,
   output logic [W-1:0] count_out,
   output logic eoc_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic eoc;
   } pps_ud_t;

   localparam logic [W-1:0] EOC_W = W'(EOC);

   pps_ud_t r;
   pps_ud_t next_r;

   // up/down count, saturating at zero and at end-of-count
   always_comb begin
      next_r = r;
      if (clear_in) begin
         next_r.cnt = '0;
      end else if (step_in && up_in && r.cnt != EOC_W) begin
         next_r.cnt = r.cnt + 1'b1;
      end else if (step_in && !up_in && r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
      next_r.eoc = (next_r.cnt == EOC_W);
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign count_out = r.cnt;
   assign eoc_out = r.eoc;
endmodule
`default_nettype wire

// ==== rtl/pps_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer
   import pps_pkg::*;
#(
   parameter int unsigned FREQ_SEL = 2,
   parameter int unsigned TICK_LEN = TICK_CYC,
   parameter int unsigned SS_LEN = SS_TICKS,
   parameter int unsigned RESTART_LEN = RESTART_TICKS,
   parameter int unsigned UV_DEB_LEN = UV_DEB_TICKS,
   parameter int unsigned UV_REST_LEN = UV_REST_TICKS,
   parameter int unsigned OVL_EOC = OVERLOAD_DELAY_MS * pps_freq_hz(FREQ_SEL) / 1000
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic overcurrent_compare_in,
   input wire logic regulation_compare_in,
   input wire logic feedback_input_low_in,
   input wire logic compensation_low_level_in,
   input wire logic undervoltage_threshold_below_in,
   input wire logic vcc_start_in,
   input wire logic vcc_low_in,
   output logic gate_enable_out,
   output logic [7:0] peak_current_limit_out,
   output logic light_load_burst_out,
   output logic secondary_feedback_out,
   output logic hv_source_out,
   output logic overload_protection_out,
   output logic disabled_out
);
   localparam int NPIN = 7;
   localparam int IX_OCP = 0;
   localparam int IX_REG = 1;
   localparam int IX_FB = 2;
   localparam int IX_COMP = 3;
   localparam int IX_UV = 4;
   localparam int IX_VST = 5;
   localparam int IX_VLO = 6;

   localparam int unsigned FNOM = pps_freq_hz(FREQ_SEL);
   localparam int unsigned BASE = CLK_HZ / FNOM;
   localparam int unsigned JDEV = BASE * JITTER_PCT / 100;
   localparam int unsigned JSTEP = CLK_HZ / (JITTER_RATE_HZ * 4 * JDEV);
   localparam int unsigned SKIP_MAX = FNOM / FREQ_FLOOR_HZ - 1;

   localparam logic [15:0] BASE16 = 16'(BASE);
   localparam logic [15:0] JDEV16 = 16'(JDEV);
   localparam logic [15:0] JSTEP_M1 = 16'(JSTEP - 1);
   localparam logic [15:0] TICK_M1 = 16'(TICK_LEN - 1);
   localparam logic [15:0] MIN_ON_M1 = 16'(MIN_ON_CYC - 1);
   localparam logic [3:0] SKIP_MAX4 = 4'(SKIP_MAX);
   localparam logic [7:0] SS_FULL = 8'(SS_LEN);
   localparam logic [15:0] RESTART_M1 = 16'(RESTART_LEN - 1);

   typedef struct packed {
      pps_state_t st;
      logic [NPIN-1:0] sy0;
      logic [NPIN-1:0] sy1;
      logic [NPIN-1:0] sy2;
      logic [NPIN-1:0] filt;
      logic [15:0] tick_cnt;
      logic tick;
      logic [15:0] jit;
      logic jit_up;
      logic [15:0] jit_cnt;
      logic [15:0] per_cnt;
      logic [15:0] on_cnt;
      logic gate;
      logic early;
      logic cyc_end;
      logic ocp_cyc;
      logic [3:0] skip_lvl;
      logic [3:0] skip_left;
      logic [7:0] ss;
      logic [15:0] rst_cnt;
      logic hv;
   } pps_reg_t;

   pps_reg_t r;
   pps_reg_t next_r;

   logic ovl_eoc;
   logic deb_eoc;
   logic rest_eoc;
   logic [NPIN-1:0] pins;
   logic [15:0] period_m1;
   logic end_on;
   logic early_now;
   logic go_run;

   assign pins = {vcc_low_in, vcc_start_in, undervoltage_threshold_below_in,
                  compensation_low_level_in, feedback_input_low_in,
                  regulation_compare_in, overcurrent_compare_in};

   // overload counter steps once per conducted cycle
   pps_updown #(
      .W(16),
      .EOC(OVL_EOC)
   ) u_overload (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .clear_in(r.st != ST_RUN),
      .step_in(r.cyc_end),
      .up_in(r.ocp_cyc),
      .count_out(),
      .eoc_out(ovl_eoc)
   );

   // undervoltage debounce counter
   pps_updown #(
      .W(16),
      .EOC(UV_DEB_LEN)
   ) u_uv_deb (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .clear_in(r.st == ST_DIS || r.st == ST_OFF || deb_eoc),
      .step_in(r.tick),
      .up_in(r.filt[IX_UV]),
      .count_out(),
      .eoc_out(deb_eoc)
   );

   // restart counter while disabled
   pps_updown #(
      .W(16),
      .EOC(UV_REST_LEN)
   ) u_uv_rest (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .clear_in(r.st != ST_DIS),
      .step_in(r.tick),
      .up_in(!r.filt[IX_UV]),
      .count_out(),
      .eoc_out(rest_eoc)
   );

   always_comb begin
      next_r = r;
      end_on = 1'b0;
      early_now = 1'b0;
      go_run = 1'b0;
      period_m1 = BASE16 + r.jit - 16'h0001;

      // three-stage pin synchroniser, accept when stages two and three agree
      next_r.sy0 = pins;
      next_r.sy1 = r.sy0;
      next_r.sy2 = r.sy1;
      for (int i = 0; i < NPIN; i++) begin
         if (r.sy1[i] == r.sy2[i]) begin
            next_r.filt[i] = r.sy2[i];
         end
      end

      // fixed timebase
      next_r.tick = 1'b0;
      if (r.tick_cnt == TICK_M1) begin
         next_r.tick_cnt = '0;
         next_r.tick = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 16'h0001;
      end

      // triangular period modulation
      if (r.jit_cnt == JSTEP_M1) begin
         next_r.jit_cnt = '0;
         if (r.jit_up) begin
            if ($signed(r.jit) >= $signed(JDEV16)) begin
               next_r.jit_up = 1'b0;
               next_r.jit = r.jit - 16'h0001;
            end else begin
               next_r.jit = r.jit + 16'h0001;
            end
         end else begin
            if ($signed(r.jit) <= -$signed(JDEV16)) begin
               next_r.jit_up = 1'b1;
               next_r.jit = r.jit + 16'h0001;
            end else begin
               next_r.jit = r.jit - 16'h0001;
            end
         end
      end else begin
         next_r.jit_cnt = r.jit_cnt + 16'h0001;
      end

      next_r.cyc_end = 1'b0;
      next_r.filt[IX_FB] = next_r.filt[IX_FB];

      unique case (r.st)
         ST_OFF: begin
            next_r.hv = 1'b1;
            next_r.gate = 1'b0;
            if (r.filt[IX_VST]) begin
               go_run = 1'b1;
            end
         end
         ST_RUN: begin
            next_r.hv = 1'b0;
            if (r.tick && r.ss < SS_FULL) begin
               next_r.ss = r.ss + 8'h01;
            end
            // on-time: cannot end before the minimum on-time
            if (r.gate) begin
               next_r.on_cnt = r.on_cnt + 16'h0001;
               early_now = r.early || (r.filt[IX_OCP] && r.on_cnt <= MIN_ON_M1);
               next_r.early = early_now;
               if (r.on_cnt >= MIN_ON_M1 && (r.filt[IX_OCP] || r.filt[IX_REG])) begin
                  end_on = 1'b1;
                  next_r.ocp_cyc = r.filt[IX_OCP];
               end else if (r.per_cnt == period_m1) begin
                  end_on = 1'b1;
                  next_r.ocp_cyc = 1'b0;
               end
            end
            if (end_on) begin
               next_r.gate = 1'b0;
               next_r.cyc_end = 1'b1;
               if (early_now) begin
                  if (r.skip_lvl != SKIP_MAX4) begin
                     next_r.skip_lvl = r.skip_lvl + 4'h1;
                  end
               end else if (r.skip_lvl != 4'h0) begin
                  next_r.skip_lvl = r.skip_lvl - 4'h1;
               end
               next_r.skip_left = next_r.skip_lvl;
            end
            // cycle boundary
            if (r.per_cnt == period_m1) begin
               next_r.per_cnt = '0;
               if (next_r.skip_left != 4'h0) begin
                  next_r.skip_left = next_r.skip_left - 4'h1;
               end else if (!r.filt[IX_COMP]) begin
                  next_r.gate = 1'b1;
                  next_r.on_cnt = '0;
                  next_r.early = 1'b0;
               end
            end else begin
               next_r.per_cnt = r.per_cnt + 16'h0001;
            end
            if (ovl_eoc) begin
               next_r.st = ST_FAULT;
               next_r.gate = 1'b0;
               next_r.rst_cnt = '0;
            end
         end
         ST_FAULT: begin
            next_r.gate = 1'b0;
            if (r.filt[IX_VLO]) begin
               next_r.hv = 1'b1;
            end else if (r.filt[IX_VST]) begin
               next_r.hv = 1'b0;
            end
            if (r.tick) begin
               if (r.rst_cnt == RESTART_M1) begin
                  go_run = 1'b1;
               end else begin
                  next_r.rst_cnt = r.rst_cnt + 16'h0001;
               end
            end
         end
         ST_DIS: begin
            next_r.gate = 1'b0;
            if (r.filt[IX_VLO]) begin
               next_r.hv = 1'b1;
            end else if (r.filt[IX_VST]) begin
               next_r.hv = 1'b0;
            end
            if (rest_eoc) begin
               go_run = 1'b1;
            end
         end
         default: begin
            next_r.st = ST_OFF;
            next_r.gate = 1'b0;
         end
      endcase

      // undervoltage disable overrides run and fault
      if (deb_eoc && (r.st == ST_RUN || r.st == ST_FAULT)) begin
         next_r.st = ST_DIS;
         next_r.gate = 1'b0;
         go_run = 1'b0;
      end

      // every entry into switching restarts the soft-start ramp
      if (go_run) begin
         next_r.st = ST_RUN;
         next_r.hv = 1'b0;
         next_r.ss = '0;
         next_r.gate = 1'b0;
         next_r.per_cnt = '0;
         next_r.skip_lvl = '0;
         next_r.skip_left = '0;
         next_r.early = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         r <= '0;
         r.st <= ST_OFF;
         r.hv <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign gate_enable_out = r.gate;
   assign peak_current_limit_out = r.ss;
   assign light_load_burst_out = (r.st == ST_RUN) && r.filt[IX_COMP];
   assign secondary_feedback_out = r.filt[IX_FB];
   assign hv_source_out = r.hv;
   assign overload_protection_out = (r.st == ST_FAULT);
   assign disabled_out = (r.st == ST_DIS);
endmodule
`default_nettype wire

// ==== bench/pps_sequencer_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer_assertions
   import pps_pkg::*;
#(
   parameter int unsigned FREQ_SEL = 2,
   parameter int unsigned TICK_LEN = 10,
   parameter int unsigned SS_LEN = 8,
   parameter int unsigned RESTART_LEN = 20
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic feedback_input_low_in,
   input wire logic gate_enable_out,
   input wire logic [7:0] peak_current_limit_out,
   input wire logic light_load_burst_out,
   input wire logic secondary_feedback_out,
   input wire logic hv_source_out,
   input wire logic overload_protection_out,
   input wire logic disabled_out
);
   localparam int BASE = CLK_HZ / pps_freq_hz(FREQ_SEL);
   localparam int PMIN = BASE - BASE * JITTER_PCT / 100 - 1;
   localparam int RMIN = (RESTART_LEN - 1) * TICK_LEN;
   int gap;
   int held;
   // cycles since last conduction start and length of the fault window
   always_ff @(posedge mclk_in) begin
      gap <= (reset_in) ? 100000 : ($rose(gate_enable_out) ? 0 : gap + 1);
      held <= (reset_in || !overload_protection_out) ? 0 : held + 1;
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   property p_limit_step;
      $changed(peak_current_limit_out) |-> peak_current_limit_out == 8'h00
         || peak_current_limit_out == $past(peak_current_limit_out) + 8'h01;
   endproperty
   a_limit_step: assert property (p_limit_step) else $error("limit jumped");
   property p_limit_max;
      peak_current_limit_out <= SS_LEN;
   endproperty
   a_limit_max: assert property (p_limit_max) else $error("limit above full");
   property p_period;
      $rose(gate_enable_out) |-> gap >= PMIN;
   endproperty
   a_period: assert property (p_period) else $error("period too short");
   property p_hv_run;
      $rose(gate_enable_out) |-> !hv_source_out;
   endproperty
   a_hv_run: assert property (p_hv_run) else $error("hv on while switching");
   property p_ovl_gate;
      overload_protection_out && $past(overload_protection_out) |-> !gate_enable_out;
   endproperty
   a_ovl_gate: assert property (p_ovl_gate) else $error("gate on in fault");
   property p_dis_gate;
      disabled_out && $past(disabled_out) |-> !gate_enable_out;
   endproperty
   a_dis_gate: assert property (p_dis_gate) else $error("gate on when disabled");
   property p_burst;
      $past(light_load_burst_out) |-> !$rose(gate_enable_out);
   endproperty
   a_burst: assert property (p_burst) else $error("cycle started in burst");
   property p_restart;
      $fell(overload_protection_out) && !disabled_out |-> held >= RMIN;
   endproperty
   a_restart: assert property (p_restart) else $error("restart cut short");
   property p_sec_on;
      feedback_input_low_in [*6] |-> secondary_feedback_out;
   endproperty
   a_sec_on: assert property (p_sec_on) else $error("secondary mode missing");
   property p_sec_off;
      (!feedback_input_low_in) [*6] |-> !secondary_feedback_out;
   endproperty
   a_sec_off: assert property (p_sec_off) else $error("secondary mode stuck");
endmodule
bind pps_sequencer pps_sequencer_assertions #(.FREQ_SEL(FREQ_SEL), .TICK_LEN(TICK_LEN),
   .SS_LEN(SS_LEN), .RESTART_LEN(RESTART_LEN)) i_pps_sequencer_assertions (
   .mclk_in(mclk_in), .reset_in(reset_in), .feedback_input_low_in(feedback_input_low_in),
   .gate_enable_out(gate_enable_out), .peak_current_limit_out(peak_current_limit_out),
   .light_load_burst_out(light_load_burst_out), .secondary_feedback_out(secondary_feedback_out),
   .hv_source_out(hv_source_out), .overload_protection_out(overload_protection_out),
   .disabled_out(disabled_out));
`default_nettype wire

// ==== bench/pps_power_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
// mode: 0 regulation ends on-time, 1 overcurrent ends it, 2 shorted output
module pps_power_stage (
   input wire logic mclk_in,
   input wire logic gate_in,
   input wire logic [1:0] mode_in,
   input wire logic [7:0] trip_in,
   output logic overcurrent_out,
   output logic regulation_out
);
   logic [7:0] on_cyc = 8'h00;
   always @(negedge mclk_in) begin
      on_cyc <= gate_in ? on_cyc + 8'h01 : 8'h00;
   end
   // a short holds the current at its limit from the very start
   assign overcurrent_out = mode_in == 2'h2
      || (gate_in && mode_in == 2'h1 && on_cyc >= trip_in);
   assign regulation_out = gate_in && mode_in == 2'h0 && on_cyc >= trip_in;
endmodule
`default_nettype wire

// ==== bench/pps_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer_tb;
   import pps_pkg::*;
   localparam int TL = 10;
   localparam int SSL = 8;
   localparam int RL = 20;
   localparam int UVL = 10;
   localparam int OVL = 16;
   localparam int BASE = CLK_HZ / FREQ_HIGH_HZ;
   localparam int JIT = BASE * JITTER_PCT / 100;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic overcurrent_compare, reg_cmp, gate, burst, sec, hv, ovl, dis;
   logic fb = 1'b0, comp = 1'b0, uv = 1'b0, vstart = 1'b0, vlow = 1'b0;
   logic [7:0] limit;
   logic [1:0] mode = 2'h0;
   int errors = 0;
   int checked = 0;
   pps_sequencer #(.FREQ_SEL(2), .TICK_LEN(TL), .SS_LEN(SSL), .RESTART_LEN(RL),
      .UV_DEB_LEN(UVL), .UV_REST_LEN(UVL), .OVL_EOC(OVL)) i_pps_sequencer (
      .mclk_in(mclk_in), .reset_in(reset_in), .overcurrent_compare_in(overcurrent_compare),
      .regulation_compare_in(reg_cmp), .feedback_input_low_in(fb),
      .compensation_low_level_in(comp), .undervoltage_threshold_below_in(uv),
      .vcc_start_in(vstart), .vcc_low_in(vlow), .gate_enable_out(gate),
      .peak_current_limit_out(limit), .light_load_burst_out(burst),
      .secondary_feedback_out(sec), .hv_source_out(hv), .overload_protection_out(ovl),
      .disabled_out(dis));
   pps_power_stage i_pps_power_stage (.mclk_in(mclk_in), .gate_in(gate), .mode_in(mode),
      .trip_in(8'h06), .overcurrent_out(overcurrent_compare), .regulation_out(reg_cmp));
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic rises(input int n, output int r);
      logic p;
      r = 0;
      repeat (n) begin
         p = gate;
         cyc(1);
         r += int'(gate === 1'b1 && p === 1'b0);
      end
   endtask
   task automatic next_rise(output int g);
      g = 0;
      while (gate === 1'b1 && g < 3000) begin cyc(1); g++; end
      while (gate !== 1'b1 && g < 3000) begin cyc(1); g++; end
   endtask
   task automatic t_start;
      int r;
      vstart = 1'b1;
      cyc(8);
      chk("hv_start", hv, 1'b0);
      chk("limit_start", limit <= 8'h01, 1'b1);
      cyc(SSL * TL + 20);
      chk("limit_full", limit, 8'(SSL));
      rises(BASE * 10, r);
      chk("rate", r >= 9 && r <= 11, 1'b1);
   endtask
   task automatic t_fb_burst;
      int r;
      fb = 1'b1;
      cyc(8);
      chk("sec_on", sec, 1'b1);
      fb = 1'b0;
      comp = 1'b1;
      cyc(8);
      chk("sec_off", sec, 1'b0);
      chk("burst_on", burst, 1'b1);
      rises(BASE * 4, r);
      chk("burst_idle", r, 0);
      comp = 1'b0;
      cyc(8);
      chk("burst_off", burst, 1'b0);
      rises(BASE * 4, r);
      chk("burst_resume", r >= 3, 1'b1);
   endtask
   task automatic t_skip;
      int g;
      mode = 2'h2;
      next_rise(g);
      next_rise(g);
      next_rise(g);
      chk("skip_gap", g >= 2 * (BASE - JIT), 1'b1);
      chk("skip_floor", g <= CLK_HZ / FREQ_FLOOR_HZ, 1'b1);
      mode = 2'h0;
      cyc(BASE * 30);
      next_rise(g);
      next_rise(g);
      chk("restored", g <= BASE + JIT + 1, 1'b1);
   endtask
   task automatic overload_delay;
      int i, r, k;
      logic p;
      for (k = 0; k < 2; k++) begin
         // let a conduction already under way end before counting rises
         while (gate === 1'b1) cyc(1);
         mode = 2'h1;
         r = 0;
         for (i = 0; i < 3000 && ovl !== 1'b1; i++) begin
            p = gate;
            cyc(1);
            r += int'(gate === 1'b1 && p === 1'b0);
         end
         chk("trip", ovl, 1'b1);
         chk("trip_count", r, OVL);
         mode = 2'h0;
         vstart = 1'b0;
         vlow = 1'b1;
         cyc(8);
         chk("hv_low", hv, 1'b1);
         vlow = 1'b0;
         vstart = 1'b1;
         cyc(8);
         chk("hv_high", hv, 1'b0);
         cyc(RL * TL - 3 * TL);
         chk("restart_wait", ovl, 1'b1);
         for (i = 0; i < 4 * TL && ovl !== 1'b0; i++) cyc(1);
         chk("restart_end", ovl, 1'b0);
         chk("restart_ss", limit <= 8'h01, 1'b1);
      end
      mode = 2'h1;
      cyc(BASE * 12);
      mode = 2'h0;
      cyc(BASE * 14);
      mode = 2'h1;
      cyc(BASE * 12);
      mode = 2'h0;
      chk("no_trip", ovl, 1'b0);
   endtask
   task automatic t_uv;
      int i;
      uv = 1'b1;
      cyc(UVL * TL / 2);
      uv = 1'b0;
      cyc(UVL * TL);
      chk("uv_glitch", dis, 1'b0);
      uv = 1'b1;
      for (i = 0; i < UVL * TL + 50 && dis !== 1'b1; i++) cyc(1);
      chk("uv_dis", dis, 1'b1);
      chk("uv_deb", i >= (UVL - 1) * TL, 1'b1);
      cyc(2);
      chk("uv_gate", gate, 1'b0);
      uv = 1'b0;
      for (i = 0; i < UVL * TL + 50 && dis !== 1'b0; i++) cyc(1);
      chk("uv_rest", dis, 1'b0);
      chk("uv_rest_len", i >= (UVL - 1) * TL, 1'b1);
      uv = 1'b1;
      cyc(UVL * TL / 2 + 20);
      uv = 1'b0;
      chk("uv_cleared", dis, 1'b0);
   endtask
   task automatic print_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      cyc(5);
      chk("rst_gate", gate, 1'b0);
      chk("rst_hv", hv, 1'b1);
      reset_in = 1'b0;
      t_start();
      t_fb_burst();
      t_skip();
      overload_delay();
      t_uv();
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge mclk_in);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
